// *** sim/fault_mgr_chk.sv ***
// checker for the converter fault manager, bound to its top module
// assumes the top module's port names and a single pclk domain
`timescale 1ns/1ps
`default_nettype none
module fault_mgr_chk #(
   parameter int hiccup_count = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire fault_mgr_pkg::sense_t sense,
   input wire logic output_at_zero,
   input wire logic group_ok_in,
   input wire logic group_ok_out,
   input wire logic group_ok_oe,
   input wire fault_mgr_pkg::shutdown_t shutdown,
   input wire logic ramp_start,
   input wire fault_mgr_pkg::phase_t phase,
   input wire logic [15:0] ov_limit_mv
);
   localparam fault_mgr_pkg::phase_t st = fault_mgr_pkg::ph_steady;
   localparam fault_mgr_pkg::phase_t dn = fault_mgr_pkg::ph_ramp_down;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic trk_off_q, prop_q, hic_on_q, mapped;
   logic [15:0] dev;
   int hic_cnt_q;
   // ********
   // helper logic
   // ********
   // address decode and tracking deviation
   assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
   assign dev = (sense.vout_mv > sense.target_mv) ? sense.vout_mv - sense.target_mv
      : sense.target_mv - sense.vout_mv;
   // shadows of config bits, taken at committed writes
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         trk_off_q <= 1'h0;
         prop_q <= 1'h0;
      end
      else if (psel && penable && pwrite)
      begin
         if (paddr == fault_mgr_pkg::fault_type_config_addr)
            trk_off_q <= pwdata[fault_mgr_pkg::ft_tr_disable_bit];
         if (paddr == fault_mgr_pkg::fault_spread_config_addr)
            prop_q <= pwdata[fault_mgr_pkg::fs_propagate_bit];
      end
   // cycles spent off since the output reached zero
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         hic_on_q <= 1'h0;
         hic_cnt_q <= 0;
      end
      else if (output_at_zero && phase == dn)
      begin
         hic_on_q <= 1'h1;
         hic_cnt_q <= 0;
      end
      else if (phase != fault_mgr_pkg::ph_off)
         hic_on_q <= 1'h0;
      else if (hic_cnt_q < hiccup_count)
         hic_cnt_q <= hic_cnt_q + 1;
   // ********
   // assertions
   // ********
   slverr_map_a: assert property (pslverr == (psel && penable && !mapped))
      else $error("slverr wrong");
   line_low_a: assert property (group_ok_out == 1'h0)
      else $error("line high");
   ot_off_a: assert property (phase == st && sense.temp_c > fault_mgr_pkg::ot_trip_c
      |-> (shutdown.regular_off || shutdown.fast_off) ##1 phase == dn)
      else $error("no ot off");
   track_fast_a: assert property (phase == fault_mgr_pkg::ph_ramp_up && !trk_off_q
      && dev > fault_mgr_pkg::track_limit_mv |-> shutdown.fast_off)
      else $error("no track off");
   ov_crowbar_a: assert property (phase != fault_mgr_pkg::ph_off
      && sense.vout_mv > sense.prebias_mv && sense.vout_mv > ov_limit_mv
      |-> shutdown.fast_off && shutdown.low_side_on)
      else $error("no crowbar");
   ov_floor_a: assert property (ov_limit_mv >= fault_mgr_pkg::ov_floor_mv)
      else $error("limit low");
   oe_prop_a: assert property (prop_q && phase == st
      && sense.temp_c > fault_mgr_pkg::ot_trip_c |=> group_ok_oe)
      else $error("no spread");
   oe_cause_a: assert property ($rose(group_ok_oe) |-> prop_q)
      else $error("spread off");
   peer_off_a: assert property (phase == st && !group_ok_in && !group_ok_oe
      |=> phase == dn && (shutdown.regular_off || shutdown.fast_off))
      else $error("peer ignored");
   hiccup_wait_a: assert property (hic_on_q && ramp_start |-> hic_cnt_q >= hiccup_count)
      else $error("early restart");
   cover property (phase == dn && shutdown.low_side_on);
   cover property (hic_on_q && ramp_start);
   cover property ($rose(group_ok_oe));
endmodule
bind converter_fault_manager fault_mgr_chk #(.hiccup_count(hiccup_count)) i_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .sense,
   .output_at_zero, .group_ok_in, .group_ok_out, .group_ok_oe, .shutdown, .ramp_start,
   .phase, .ov_limit_mv);
`default_nettype wire

// *** sim/group_partner.sv ***
// far side of the group line: peer members and the power manager
// assumes the bench commands peer faults and the manager's relay
`timescale 1ns/1ps
`default_nettype none
module group_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic dut_oe,
   input wire logic dut_out,
   input wire logic [3:0] peer_pull,
   input wire logic relay_en,
   output logic group_line
);
   logic [3:0] line;
   logic relay_q;
   // four pulled-up group lines, line 0 holds the dut's group
   assign line = ~(peer_pull | {3'h0, dut_oe & ~dut_out} | {4{relay_q}});
   assign group_line = line[0];
   // manager drops every group once any line goes low
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         relay_q <= 1'h0;
      else
         relay_q <= relay_en && (line != 4'hf);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the converter fault manager
// assumes group_partner closes the wired group line
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int hic = 50;
   localparam fault_mgr_pkg::phase_t dn = fault_mgr_pkg::ph_ramp_down;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, relay_en;
   logic output_at_zero, ramp_done, group_ok_in, group_ok_out, group_ok_oe, ramp_start;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] ov_limit_mv;
   logic [3:0] peer_pull;
   fault_mgr_pkg::sense_t sense;
   fault_mgr_pkg::shutdown_t shutdown;
   fault_mgr_pkg::phase_t phase;
   int num_errors, tests_run, cyc, n;
   // ********
   // design, far side, clock
   // ********
   converter_fault_manager #(.hiccup_count(hic)) i_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sense, .output_at_zero,
      .ramp_done, .group_ok_in, .group_ok_out, .group_ok_oe, .shutdown, .ramp_start,
      .phase, .ov_limit_mv);
   group_partner i_far (.pclk, .presetn, .dut_oe(group_ok_oe), .dut_out(group_ok_out),
      .peer_pull, .relay_en, .group_line(group_ok_in));
   initial
   begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic tk();
      @(posedge pclk);
      #1;
   endtask
   task automatic rst(input logic rdn);
      @(posedge pclk);
      presetn <= 1'h0;
      sense <= '{8'h19, 16'h03e8, 16'h03e8, 16'h03e8, 16'h0000, 16'h0384, 1'h0};
      output_at_zero <= 1'h0;
      ramp_done <= rdn;
      relay_en <= 1'h0;
      peer_pull <= 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      repeat (4) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rv, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rv = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      logic e;
      apb(1'h0, a, 32'h0, r, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'h1, a, d, x, e);
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_regs();
      logic e;
      rst(1'h1);
      rd(12'h000);
      chk(r, 32'h0, "type cfg");
      rd(12'h004);
      chk(r, 32'h0, "spread cfg");
      rd(12'h008);
      chk(r, 32'h3f, "flags");
      apb(1'h0, 12'h020, 32'h0, r, e);
      chk({31'h0, e}, 32'h1, "unmapped err");
      chk(r, 32'h0, "unmapped data");
      wr(12'h00c, 32'h90);
      rd(12'h00c);
      chk(r, 32'h82, "pct top");
      tk();
      tk();
      chk(ov_limit_mv, 16'h0514, "limit 130");
      wr(12'h00c, 32'h50);
      rd(12'h00c);
      chk(r, 32'h6e, "pct bottom");
      tk();
      tk();
      chk(ov_limit_mv, 16'h044c, "limit 110");
      sense.setpoint_mv <= 16'h0320;
      repeat (3) tk();
      chk(ov_limit_mv, 16'h03e8, "limit floor");
      $display("test regs done");
   endtask
   task automatic t_ot();
      rst(1'h1);
      sense.temp_c <= 8'h79;
      tk();
      chk(shutdown, 3'h4, "ot ramp off");
      tk();
      chk(phase, dn, "ot down");
      rd(12'h008);
      chk(r[0], 1'h0, "ot flag");
      sense.temp_c <= 8'h73;
      output_at_zero <= 1'h1;
      repeat (hic + 20) tk();
      chk(phase, fault_mgr_pkg::ph_off, "ot held warm");
      sense.temp_c <= 8'h6d;
      output_at_zero <= 1'h0;
      repeat (3) tk();
      chk(phase == fault_mgr_pkg::ph_off, 1'h0, "ot restart");
      $display("test overheat done");
   endtask
   task automatic t_trk();
      rst(1'h1);
      sense.target_mv <= 16'h012c;
      tk();
      chk(shutdown, 3'h0, "steady no track");
      rst(1'h0);
      chk(phase, fault_mgr_pkg::ph_ramp_up, "ramping");
      wr(12'h000, 32'h20);
      sense.target_mv <= 16'h02ed;
      tk();
      chk(shutdown, 3'h0, "track disabled");
      wr(12'h000, 32'h0);
      sense.target_mv <= 16'h02ee;
      tk();
      chk(shutdown, 3'h0, "track at 250");
      sense.target_mv <= 16'h02ed;
      tk();
      chk(shutdown, 3'h2, "track fast off");
      rd(12'h008);
      chk(r[1], 1'h0, "track flag");
      $display("test tracking done");
   endtask
   task automatic t_err();
      rst(1'h1);
      sense.vout_mv <= 16'h044c;
      tk();
      chk(shutdown, 3'h0, "at limit");
      sense.vout_mv <= 16'h044d;
      sense.temp_c <= 8'h79;
      tk();
      chk(shutdown[1:0], 2'h3, "error wins");
      rd(12'h008);
      chk(r[2], 1'h0, "high flag");
      $display("test error done");
   endtask
   task automatic t_uv();
      rst(1'h1);
      sense.vout_mv <= 16'h0383;
      tk();
      chk(shutdown, 3'h4, "uv ramp off");
      rd(12'h008);
      chk(r[3], 1'h0, "uv flag");
      output_at_zero <= 1'h1;
      n = 0;
      do
      begin
         tk();
         n++;
      end
      while (ramp_start !== 1'h1 && n < 300);
      chk(n, hic + 1, "hiccup length");
      rst(1'h1);
      sense.current_limit <= 1'h1;
      sense.vout_mv <= 16'h0383;
      tk();
      chk(shutdown, 3'h2, "oc fast off");
      rd(12'h008);
      chk(r[4], 1'h0, "oc flag");
      $display("test low output done");
   endtask
   task automatic t_grp();
      rst(1'h1);
      wr(12'h004, 32'h1);
      sense.temp_c <= 8'h79;
      tk();
      tk();
      chk(group_ok_oe, 1'h1, "own pull");
      chk(group_ok_in, 1'h0, "line low");
      chk(group_ok_out, 1'h0, "never high");
      rst(1'h1);
      sense.temp_c <= 8'h79;
      tk();
      tk();
      chk(group_ok_oe, 1'h0, "no spread");
      rst(1'h1);
      relay_en <= 1'h1;
      peer_pull <= 4'h4;
      repeat (3) tk();
      chk(phase, dn, "peer off");
      chk(shutdown, 3'h4, "bystander ramp");
      $display("test group done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ********
   // main sequence and timeout
   // ********
   initial
   begin
      {presetn, psel, penable, pwrite, output_at_zero, ramp_done, relay_en} = 7'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sense = '0;
      peer_pull = 4'h0;
      t_regs();
      t_ot();
      t_trk();
      t_err();
      t_uv();
      t_grp();
      finish_test();
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         finish_test();
      end
   end
endmodule
`default_nettype wire

// *** verilog/converter_fault_manager.sv ***
// converter fault manager: detection, shutdown choice, hiccup, group line
// assumes synchronous sense inputs, an APB master, a wired-low group line
//
// Overview of operation
// RULE1: over 120 C: overheat fault, ramped off, flag 0.
// RULE2: non-latching overheat restarts below 110 C.
// RULE3: tracking checked only during ramp-up.
// RULE4: tracking deviation over 250 mV: fault, off, flag 0.
// RULE5: tracking fault turns both switches off at once.
// RULE6: a fault type config bit disables tracking.
// RULE7: above pre-bias, output over high limit: error, off, flag 0.
// RULE8: high-output error: high side off, low side on together.
// RULE9: high limit 110 to 130 percent of setpoint, floor 1.0 V.
// RULE10: a group is one to 32 modules on one line.
// RULE11: propagate only when the spread config bit is set.
// RULE12: propagating, own fault or error pulls the line low.
// RULE13: line pulled low by a peer starts turn-off.
// RULE14: shared fault: bystanders ramp off, faulty one own type.
// RULE15: shared error: bystanders fast off, faulty one low side on. Code: bystanders ramp off (regular_off).
// RULE16: 130 ms hiccup from output zero to next ramp-up.
// RULE17: the manager supervises up to four groups.
// RULE18: the manager pulls configured other lines low.
// RULE19: non-latching retries every 130 ms until cause clears. Code: after the hiccup it waits in off until cause_gone.
// RULE20: latching stays off until cause gone and clear or recycle.
// RULE21: undervoltage in steady state, no current limit: ramped off.
// RULE22: current limit, output under low limit: fast off, flag 0.
// RULE23: error with fault together: error response wins.
// RULE24: group line only pulled low or released.
`timescale 1ns/1ps
`default_nettype none

module converter_fault_manager #(
   parameter int hiccup_count = fault_mgr_pkg::hiccup_cycles
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fault_mgr_pkg::sense_t sense,
   input wire logic output_at_zero,
   input wire logic ramp_done,
   input wire logic group_ok_in,
   output logic group_ok_out,
   output logic group_ok_oe,
   output fault_mgr_pkg::shutdown_t shutdown,
   output logic ramp_start,
   output fault_mgr_pkg::phase_t phase,
   output logic [15:0] ov_limit_mv
);

   // ****************************************
   // declarations
   // ****************************************
   logic [5:0] fault_type_q;
   logic fault_spread_q;
   logic [5:0] flags_q;
   logic [7:0] ov_pct_q;
   logic turn_on_q;
   logic turn_on_prev_q;
   fault_mgr_pkg::phase_t phase_q;
   logic [31:0] hiccup_q;
   logic holdoff_q;
   logic latched_q;
   logic err_active_q, fast_fault_q;
   logic self_fault_q;
   logic [15:0] ov_limit_q;
   logic [23:0] ov_scaled;
   logic [15:0] track_diff;
   logic ot_event, tr_event, ov_event, uv_event, oc_event;
   logic any_fault, any_error, own_event, peer_event;
   logic own_latch;
   logic wr_en, rd_en;
   logic [5:0] flag_set, flag_clr;
   logic cause_gone;

   // ****************************************
   // apb slave
   // ****************************************
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1; // zero wait states

   // unmapped addresses answer with an error
   always_comb
   begin
      pslverr = 1'b0;
      if (psel && penable)
      begin
         case (paddr)
            fault_mgr_pkg::fault_type_config_addr,
            fault_mgr_pkg::fault_spread_config_addr,
            fault_mgr_pkg::protection_flags_reg_addr,
            fault_mgr_pkg::ov_threshold_addr,
            fault_mgr_pkg::control_addr: pslverr = 1'b0;
            default: pslverr = 1'b1;
         endcase
      end
   end

   // read data loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            fault_mgr_pkg::fault_type_config_addr: prdata <= {26'h0, fault_type_q};
            fault_mgr_pkg::fault_spread_config_addr: prdata <= {31'h0, fault_spread_q};
            fault_mgr_pkg::protection_flags_reg_addr: prdata <= {26'h0, flags_q};
            fault_mgr_pkg::ov_threshold_addr: prdata <= {24'h0, ov_pct_q};
            fault_mgr_pkg::control_addr: prdata <= {30'h0, phase_q == fault_mgr_pkg::ph_off,
                                                    turn_on_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_type_q <= fault_mgr_pkg::fault_type_reset;
         fault_spread_q <= fault_mgr_pkg::fault_spread_reset;
         ov_pct_q <= fault_mgr_pkg::ov_pct_reset;
         turn_on_q <= fault_mgr_pkg::control_reset;
      end
      else if (wr_en)
      begin
         case (paddr)
            fault_mgr_pkg::fault_type_config_addr: fault_type_q <= pwdata[5:0];
            fault_mgr_pkg::fault_spread_config_addr: fault_spread_q <= pwdata[0];
            fault_mgr_pkg::ov_threshold_addr:
            begin
               // clamp into the legal band [RULE9]
               if (pwdata[7:0] < fault_mgr_pkg::ov_pct_min)
                  ov_pct_q <= fault_mgr_pkg::ov_pct_min;
               else if (pwdata[7:0] > fault_mgr_pkg::ov_pct_max)
                  ov_pct_q <= fault_mgr_pkg::ov_pct_max;
               else
                  ov_pct_q <= pwdata[7:0];
            end
            fault_mgr_pkg::control_addr: turn_on_q <= pwdata[fault_mgr_pkg::ctl_turn_on_bit];
            default: ;
         endcase
      end
   end

   // ****************************************
   // detection
   // ****************************************
   // effective high-output limit, floored at 1.0 V
   assign ov_scaled = 24'(sense.setpoint_mv * ov_pct_q / 16'd100);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ov_limit_q <= 16'hffff;
      else if (ov_scaled[15:0] < fault_mgr_pkg::ov_floor_mv || ov_scaled[23:16] != 8'h00)
         ov_limit_q <= (ov_scaled[23:16] != 8'h00) ? 16'hffff : fault_mgr_pkg::ov_floor_mv; // [RULE9]
      else
         ov_limit_q <= ov_scaled[15:0];
   end
   assign ov_limit_mv = ov_limit_q;

   assign track_diff = (sense.vout_mv > sense.target_mv) ? sense.vout_mv - sense.target_mv
                                                         : sense.target_mv - sense.vout_mv;

   // overheat watched always
   assign ot_event = sense.temp_c > fault_mgr_pkg::ot_trip_c; // [RULE1]
   // tracking only while ramping up and not disabled
   assign tr_event = phase_q == fault_mgr_pkg::ph_ramp_up // [RULE3]
                     && !fault_type_q[fault_mgr_pkg::ft_tr_disable_bit] // [RULE6]
                     && track_diff > fault_mgr_pkg::track_limit_mv; // [RULE4]
   // high output once above pre-bias
   assign ov_event = sense.vout_mv > sense.prebias_mv && sense.vout_mv > ov_limit_q; // [RULE7]
   // undervoltage only in steady state without current limit
   assign uv_event = phase_q == fault_mgr_pkg::ph_steady && !sense.current_limit
                     && sense.vout_mv < sense.uv_thresh_mv; // [RULE21]
   // overcurrent: current limiting drags output under the low threshold
   assign oc_event = sense.vout_mv > sense.prebias_mv && sense.current_limit
                     && sense.vout_mv < sense.uv_thresh_mv; // [RULE22]

   assign any_error = ov_event;
   assign any_fault = ot_event || tr_event || uv_event || oc_event;
   assign own_event = any_error || any_fault;
   // a peer pulls the line, not us
   assign peer_event = !group_ok_in && !group_ok_oe; // [RULE13]

   // latching type of the causes present now
   assign own_latch = (ot_event && fault_type_q[fault_mgr_pkg::ft_ot_latch_bit])
                   || (tr_event && fault_type_q[fault_mgr_pkg::ft_tr_latch_bit])
                   || (oc_event && fault_type_q[fault_mgr_pkg::ft_oc_latch_bit])
                   || (uv_event && fault_type_q[fault_mgr_pkg::ft_uv_latch_bit])
                   || (ov_event && fault_type_q[fault_mgr_pkg::ft_ov_latch_bit]);

   // ****************************************
   // status flags, active low
   // ****************************************
   assign flag_set = {1'b0, oc_event, uv_event, ov_event, tr_event, ot_event};
   // writing 1 to one of flag bits 4:0 clears it back to 1
   assign flag_clr = (wr_en && paddr == fault_mgr_pkg::protection_flags_reg_addr)
                     ? pwdata[5:0] : 6'h00;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_q <= fault_mgr_pkg::flags_reset;
      else
      begin
         // detection beats a same-cycle clear [RULE1] [RULE4] [RULE7] [RULE21] [RULE22]
         flags_q[4:0] <= (flags_q[4:0] | flag_clr[4:0]) & ~flag_set[4:0];
         // heat warning follows temperature with hysteresis
         if (ot_event)
            flags_q[fault_mgr_pkg::fl_heat_warn] <= 1'b0;
         else if (sense.temp_c < fault_mgr_pkg::ot_warn_c)
            flags_q[fault_mgr_pkg::fl_heat_warn] <= 1'b1;
      end
   end

   // ****************************************
   // shutdown selection
   // ****************************************
   // what caused the current off period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_active_q <= 1'b0;
         fast_fault_q <= 1'b0;
         self_fault_q <= 1'b0;
      end
      else if (phase_q == fault_mgr_pkg::ph_off)
      begin
         err_active_q <= 1'b0;
         fast_fault_q <= 1'b0;
         self_fault_q <= 1'b0;
      end
      else if (own_event)
      begin
         err_active_q <= err_active_q || any_error;
         fast_fault_q <= fast_fault_q || tr_event || oc_event; // [RULE5]
         self_fault_q <= 1'b1;
      end
   end

   always_comb
   begin
      shutdown = '0;
      if (any_error || (self_fault_q && err_active_q))
      begin
         // error wins over any simultaneous fault [RULE23]
         shutdown.fast_off = 1'b1; // [RULE8] [RULE15]
         shutdown.low_side_on = 1'b1; // [RULE8] [RULE15]
      end
      else if (tr_event || oc_event || (self_fault_q && fast_fault_q))
         shutdown.fast_off = 1'b1; // [RULE5] [RULE22]
      else if (ot_event || uv_event || self_fault_q)
         shutdown.regular_off = 1'b1; // [RULE1] [RULE21] [RULE14]
      else if (peer_event)
         shutdown.regular_off = 1'b1; // [RULE14]
   end
   // the shared line carries no type, so bystanders ramp off [RULE15]

   // ****************************************
   // group line, open drain
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         group_ok_oe <= 1'b0;
      else
         group_ok_oe <= fault_spread_q // [RULE11]
                        && (own_event || (self_fault_q && phase_q != fault_mgr_pkg::ph_off)); // [RULE12]
   end
   assign group_ok_out = 1'b0; // only ever pulls low [RULE24]

   // ****************************************
   // phase and hiccup restart
   // ****************************************
   assign cause_gone = !own_event && !peer_event && sense.temp_c < fault_mgr_pkg::ot_warn_c; // [RULE2]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         turn_on_prev_q <= 1'b0;
      else
         turn_on_prev_q <= turn_on_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_q <= fault_mgr_pkg::ph_off;
         hiccup_q <= 32'h0;
         holdoff_q <= 1'b0;
         latched_q <= 1'b0;
      end
      else
      begin
         case (phase_q)
            fault_mgr_pkg::ph_off:
            begin
               // a latch is released by flag clear or turn-on recycle [RULE20]
               if (latched_q && ((flags_q[4:0] == 5'h1f) || (turn_on_q && !turn_on_prev_q)))
                  latched_q <= 1'b0;
               if (hiccup_q != 32'h0)
                  hiccup_q <= hiccup_q - 32'h1; // [RULE16]
               else if (turn_on_q && !latched_q && cause_gone)
               begin
                  phase_q <= fault_mgr_pkg::ph_ramp_up; // retry after hiccup [RULE19]
                  holdoff_q <= 1'b0;
               end
            end
            fault_mgr_pkg::ph_ramp_up, fault_mgr_pkg::ph_steady:
            begin
               if (own_event || peer_event || !turn_on_q)
               begin
                  phase_q <= fault_mgr_pkg::ph_ramp_down;
                  holdoff_q <= own_event || peer_event;
                  latched_q <= own_latch; // [RULE20]
               end
               else if (phase_q == fault_mgr_pkg::ph_ramp_up && ramp_done)
                  phase_q <= fault_mgr_pkg::ph_steady;
            end
            fault_mgr_pkg::ph_ramp_down:
            begin
               if (own_latch)
                  latched_q <= 1'b1;
               // hiccup timed from output reaching zero [RULE16]
               if (output_at_zero)
               begin
                  phase_q <= fault_mgr_pkg::ph_off;
                  hiccup_q <= holdoff_q ? 32'(hiccup_count) : 32'h0;
               end
            end
            default: phase_q <= fault_mgr_pkg::ph_off;
         endcase
      end
   end

   assign phase = phase_q;
   assign ramp_start = phase_q == fault_mgr_pkg::ph_off && hiccup_q == 32'h0
                       && turn_on_q && !latched_q && cause_gone;

endmodule

`default_nettype wire

// *** verilog/fault_mgr_pkg.sv ***
// package for the converter fault manager: register map, layouts, timing
// assumes a 40 MHz pclk and an APB slave for software access
package fault_mgr_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [11:0] fault_type_config_addr = 12'h000;
   localparam logic [11:0] fault_spread_config_addr = 12'h004;
   localparam logic [11:0] protection_flags_reg_addr = 12'h008;
   localparam logic [11:0] ov_threshold_addr = 12'h00c;
   localparam logic [11:0] control_addr = 12'h010;

   // fault_type_config fields (bits 0-4: 1 = latching, bit 5: 1 = tracking off)
   localparam int ft_ot_latch_bit = 0;
   localparam int ft_tr_latch_bit = 1;
   localparam int ft_oc_latch_bit = 2;
   localparam int ft_uv_latch_bit = 3;
   localparam int ft_ov_latch_bit = 4;
   localparam int ft_tr_disable_bit = 5;
   // fault_spread_config fields
   localparam int fs_propagate_bit = 0;
   // control fields
   localparam int ctl_turn_on_bit = 0;

   // protection_flags_reg bit positions (active low)
   localparam int fl_overheat = 0;
   localparam int fl_ramp_dev = 1;
   localparam int fl_high_out = 2;
   localparam int fl_low_out = 3;
   localparam int fl_excess_cur = 4;
   localparam int fl_heat_warn = 5;

   // reset values
   localparam logic [5:0] fault_type_reset = 6'h00;
   localparam logic [0:0] fault_spread_reset = 1'h0;
   localparam logic [5:0] flags_reset = 6'h3f;
   localparam logic [7:0] ov_pct_reset = 8'h6e; // 110 percent
   localparam logic [0:0] control_reset = 1'h1;

   // thresholds in deg C, mV and percent
   localparam logic [7:0] ot_trip_c = 8'h78; // 120 C
   localparam logic [7:0] ot_warn_c = 8'h6e; // 110 C
   localparam logic [15:0] track_limit_mv = 16'h00fa; // 250 mV
   localparam logic [15:0] ov_floor_mv = 16'h03e8; // 1.0 V
   localparam logic [7:0] ov_pct_min = 8'h6e; // 110 percent
   localparam logic [7:0] ov_pct_max = 8'h82; // 130 percent

   // hiccup time and its cycle count at 40 MHz
   localparam int hiccup_ms = 130;
   localparam int clk_khz = 40000;
   localparam int hiccup_cycles = hiccup_ms * clk_khz;

   // converter phases
   typedef enum logic [1:0] {ph_off, ph_ramp_up, ph_steady, ph_ramp_down} phase_t;

   // switch commands toward the power stage
   typedef struct packed {
      logic regular_off; // ramp the output down
      logic fast_off;    // both switches off now
      logic low_side_on; // crowbar the output
   } shutdown_t;

   // analog measurements presented each cycle
   typedef struct packed {
      logic [7:0] temp_c;
      logic [15:0] vout_mv;
      logic [15:0] target_mv;
      logic [15:0] setpoint_mv;
      logic [15:0] prebias_mv;
      logic [15:0] uv_thresh_mv;
      logic current_limit;
   } sense_t;

endpackage

`default_nettype wire
